/* File: logic/tss_pkg.sv */
// Constants, types and register map of the transfer switch sequencer
// Overview of operation
// - Start generator, run fail timer, await ready
// - Enabled alarm when fail timer ends unready
// - Clear generator alarm when any source good
// - Fail timer and alarm need auxiliary supply
// - Fail timer fixed 300 s; alarm enable off
// - Time on-load test, alarm when unfinished
// - Time off-load test, alarm when unfinished
// - Preferred normal source is selectable
// - Utility pair: transfer to alternate on loss
// - Utility pair: return only with auto return
// - Utility-generator: start generator on loss
// - Load to generator only when ready; return
// - Cool-down signal only after return to normal
// - Utility pair: LED on when OK, blink otherwise
// - Utility pair: other LED blinks unless also good
// - Generator LED off, status OFF without start
// - Started but unready: blink, Out Range
// - OK only when all enabled detections good
// - Out Range when any enabled detection bad, except unstarted generator OFF
// - Utility two states; generator adds OFF
// - Stop after 60 s cool-down, after start
package tss_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [8:0] GEN_FAIL_S = 9'h12c;
  localparam logic [8:0] GEN_COOL_S = 9'h03c;
  localparam logic [8:0] ON_LOAD_TEST_S = 9'h000;
  localparam logic [8:0] OFF_LOAD_TEST_S = 9'h000;
  localparam logic [8:0] SEC_MAX = 9'h1ff;

  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_CMD = 32'h0000_0004;
  localparam logic [31:0] REG_DET_EN = 32'h0000_0008;
  localparam logic [31:0] REG_STATUS = 32'h0000_000c;

  localparam int CMD_ON_LOAD_BIT = 0;
  localparam int CMD_OFF_LOAD_BIT = 1;
  localparam int CMD_END_TEST_BIT = 2;
  localparam int CMD_CLR_TEST_ALARM_BIT = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register: bit0 alarm_en, bit1 auto_return, bit2 swap, bit3 app_gen
  typedef struct packed {
    logic app_gen;
    logic swap;
    logic auto_return;
    logic alarm_en;
  } tss_ctrl_t;

  localparam tss_ctrl_t CTRL_RESET = 4'h0;
  localparam logic [7:0] DET_EN_RESET = 8'hff;

  typedef struct packed {
    logic [3:0] second_source;
    logic [3:0] first_source;
  } tss_det_t;

  typedef enum logic [1:0] {
    SRC_OK = 2'h0,
    SRC_OUT_RANGE = 2'h1,
    SRC_OFF = 2'h2
  } tss_src_status_t;

  typedef enum logic [1:0] {
    SEQ_ON_NORMAL,
    SEQ_GEN_WAIT,
    SEQ_ON_ALT,
    SEQ_COOL
  } tss_seq_state_t;

endpackage : tss_pkg

/* File: logic/tss_sequencer.sv */
// Transfer switch sequencer with AXI4-Lite control and status registers
`timescale 1ns/1ps
`default_nettype none
module tss_sequencer #(
  parameter int TICK_CYCLES = tss_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tss_pkg::tss_det_t det_in_range,
  input wire logic aux_power_present,
  input wire logic gen_ready,
  output logic gen_start,
  output logic gen_cool_down,
  output logic load_on_alt,
  output logic led_first,
  output logic led_second,
  output logic gen_alarm,
  output logic test_alarm
);
  import tss_pkg::*;

  localparam logic [26:0] TICK_LAST = 27'(TICK_CYCLES - 1);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  function automatic logic src_good(input logic [3:0] det, input logic [3:0] en);
    src_good = &(det | ~en);
  endfunction : src_good

  function automatic logic led_of(input tss_src_status_t st, input logic blink);
    led_of = (st == SRC_OK) ? 1'b1 : ((st == SRC_OUT_RANGE) ? blink : 1'b0);
  endfunction : led_of

  function automatic logic known_addr(input logic [31:0] a);
    known_addr = (a == REG_CTRL) || (a == REG_CMD) || (a == REG_DET_EN) || (a == REG_STATUS);
  endfunction : known_addr

  // Bus slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_write;

  // Block state
  tss_ctrl_t ctrl_q;
  logic [7:0] det_en_q;
  logic [26:0] tick_cnt_q;
  logic tick_q, blink_q;
  tss_seq_state_t state_q, state_d;
  logic [8:0] sec_q;
  logic gen_start_q, gen_cool_q, load_alt_q, gen_alarm_q;
  logic led_first_q, led_second_q;
  logic test_active_q, test_off_q, test_alarm_q;
  logic [8:0] test_sec_q, test_limit;
  logic cmd_on_load, cmd_off_load, cmd_end_test, cmd_clr_test;
  logic norm_good, alt_good, norm_ok, alt_ok, fail_expired, gen_alarm_set;
  tss_src_status_t norm_stat, alt_stat, first_stat, second_stat;
  logic [31:0] status_word;

  // Command bits act once, in the cycle the write lands
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign cmd_on_load = do_write && (awaddr_q == REG_CMD) && wstrb_q[0] && wdata_q[CMD_ON_LOAD_BIT];
  assign cmd_off_load = do_write && (awaddr_q == REG_CMD) && wstrb_q[0] && wdata_q[CMD_OFF_LOAD_BIT];
  assign cmd_end_test = do_write && (awaddr_q == REG_CMD) && wstrb_q[0] && wdata_q[CMD_END_TEST_BIT];
  assign cmd_clr_test = do_write && (awaddr_q == REG_CMD) && wstrb_q[0] && wdata_q[CMD_CLR_TEST_ALARM_BIT];

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      awaddr_q <= 32'h0;
    end else if (awready_q && s_axi_awvalid) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (bvalid_q && s_axi_bready) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (wready_q && s_axi_wvalid) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (bvalid_q && s_axi_bready) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= known_addr(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Writable configuration; only the low byte holds fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
      det_en_q <= DET_EN_RESET;
    end else if (do_write && wstrb_q[0]) begin
      if (awaddr_q == REG_CTRL) begin
        ctrl_q <= wdata_q[3:0];
      end
      if (awaddr_q == REG_DET_EN) begin
        det_en_q <= wdata_q[7:0];
      end
    end
  end

  assign status_word = {20'h0, state_q, test_active_q, test_alarm_q, gen_alarm_q, gen_cool_q,
                        load_alt_q, gen_start_q, second_stat, first_stat};

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (arready_q && s_axi_arvalid) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == REG_CTRL) begin
        rdata_q <= {28'h0, ctrl_q};
      end else if (s_axi_araddr == REG_DET_EN) begin
        rdata_q <= {24'h0, det_en_q};
      end else if (s_axi_araddr == REG_STATUS) begin
        rdata_q <= status_word;
      end else begin
        rdata_q <= 32'h0;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // One-second tick and blink phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 27'h0;
      tick_q <= 1'b0;
      blink_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 27'h0 : tick_cnt_q + 27'h1;
      if (tick_q) begin
        blink_q <= !blink_q;
      end
    end
  end

  // Source qualification; the alternate is the generator in utility-generator use
  always_comb begin
    norm_good = ctrl_q.swap ? src_good(det_in_range.second_source, det_en_q[7:4])
                            : src_good(det_in_range.first_source, det_en_q[3:0]);
    alt_good = ctrl_q.swap ? src_good(det_in_range.first_source, det_en_q[3:0])
                           : src_good(det_in_range.second_source, det_en_q[7:4]);
    norm_stat = norm_good ? SRC_OK : SRC_OUT_RANGE;
    if (ctrl_q.app_gen && !gen_start_q) begin
      alt_stat = SRC_OFF;
    end else if (ctrl_q.app_gen && !gen_ready) begin
      alt_stat = SRC_OUT_RANGE;
    end else begin
      alt_stat = alt_good ? SRC_OK : SRC_OUT_RANGE;
    end
    first_stat = ctrl_q.swap ? alt_stat : norm_stat;
    second_stat = ctrl_q.swap ? norm_stat : alt_stat;
    norm_ok = (norm_stat == SRC_OK);
    alt_ok = (alt_stat == SRC_OK);
  end

  // Indicators: an out-of-range source blinks, so it goes dark every other second even while the other is good
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_first_q <= 1'b0;
      led_second_q <= 1'b0;
    end else begin
      led_first_q <= led_of(first_stat, blink_q);
      led_second_q <= led_of(second_stat, blink_q);
    end
  end

  // Transfer sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SEQ_ON_NORMAL: begin
        if (!norm_ok && ctrl_q.app_gen) begin
          state_d = SEQ_GEN_WAIT;
        end else if (!norm_ok && alt_ok) begin
          state_d = SEQ_ON_ALT;
        end
      end
      SEQ_GEN_WAIT: begin
        if (norm_ok) begin
          state_d = SEQ_COOL;
        end else if (alt_ok) begin
          state_d = SEQ_ON_ALT;
        end
      end
      SEQ_ON_ALT: begin
        if (norm_ok && ctrl_q.auto_return) begin
          state_d = ctrl_q.app_gen ? SEQ_COOL : SEQ_ON_NORMAL;
        end
      end
      SEQ_COOL: begin
        if (!norm_ok) begin
          state_d = SEQ_GEN_WAIT;
        end else if (sec_q >= GEN_COOL_S) begin
          state_d = SEQ_ON_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= SEQ_ON_NORMAL;
      gen_start_q <= 1'b0;
      gen_cool_q <= 1'b0;
      load_alt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gen_start_q <= ctrl_q.app_gen && (state_d != SEQ_ON_NORMAL);
      gen_cool_q <= (state_d == SEQ_COOL);
      load_alt_q <= (state_d == SEQ_ON_ALT);
    end
  end

  // Seconds spent in the current state; the fail wait holds without auxiliary supply
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_q <= 9'h000;
    end else if (state_d != state_q) begin
      sec_q <= 9'h000;
    end else if (tick_q && sec_q != SEC_MAX && (state_q != SEQ_GEN_WAIT || aux_power_present)) begin
      sec_q <= sec_q + 9'h001;
    end
  end

  assign fail_expired = (state_q == SEQ_GEN_WAIT) && aux_power_present && !gen_ready
                        && (sec_q >= GEN_FAIL_S);
  assign gen_alarm_set = fail_expired && ctrl_q.alarm_en;

  // Generator alarm; a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_alarm_q <= 1'b0;
    end else if (gen_alarm_set) begin
      gen_alarm_q <= 1'b1;
    end else if (norm_ok || alt_ok) begin
      gen_alarm_q <= 1'b0;
    end
  end

  assign test_limit = test_off_q ? OFF_LOAD_TEST_S : ON_LOAD_TEST_S;

  // Load test timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_active_q <= 1'b0;
      test_off_q <= 1'b0;
      test_sec_q <= 9'h000;
    end else if (!test_active_q && (cmd_on_load || cmd_off_load)) begin
      test_active_q <= 1'b1;
      test_off_q <= !cmd_on_load;
      test_sec_q <= 9'h000;
    end else if (cmd_end_test) begin
      test_active_q <= 1'b0;
    end else if (test_active_q && tick_q && test_sec_q != SEC_MAX) begin
      test_sec_q <= test_sec_q + 9'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_alarm_q <= 1'b0;
    end else if (test_active_q && test_sec_q >= test_limit) begin
      test_alarm_q <= 1'b1;
    end else if (cmd_clr_test) begin
      test_alarm_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign gen_start = gen_start_q;
  assign gen_cool_down = gen_cool_q;
  assign load_on_alt = load_alt_q;
  assign led_first = led_first_q;
  assign led_second = led_second_q;
  assign gen_alarm = gen_alarm_q;
  assign test_alarm = test_alarm_q;

  AST_START_ON_LOSS: assert property ((state_q == SEQ_ON_NORMAL && ctrl_q.app_gen && !norm_ok) |=> gen_start_q)
    else $error("generator start missing after normal loss");
  AST_LOAD_NEEDS_READY: assert property (($rose(load_alt_q) && $past(ctrl_q.app_gen)) |-> $past(gen_ready))
    else $error("load moved to generator before ready");
  AST_RETURN_AUTO_ONLY: assert property ($fell(load_alt_q) |-> $past(ctrl_q.auto_return))
    else $error("return without auto return");
  AST_COOL_ON_NORMAL: assert property (gen_cool_q |-> !load_alt_q && gen_start_q)
    else $error("cool-down while load on generator");
  AST_ALARM_SET: assert property (gen_alarm_set |=> gen_alarm_q)
    else $error("generator alarm not raised");
  AST_ALARM_CLEAR: assert property ((gen_alarm_q && (norm_ok || alt_ok) && !gen_alarm_set) |=> !gen_alarm_q)
    else $error("generator alarm not cleared");
  AST_NO_AUX_NO_ALARM: assert property ((!aux_power_present && !gen_alarm_q) |=> !gen_alarm_q)
    else $error("generator alarm without auxiliary supply");
  AST_FAIL_TIME: assert property ($rose(gen_alarm_q) |-> $past(sec_q) >= GEN_FAIL_S)
    else $error("generator alarm before fail time");
  AST_TEST_ALARM: assert property ((test_active_q && test_sec_q >= test_limit) |=> test_alarm_q)
    else $error("test alarm not raised");
  AST_GEN_LED_OFF: assert property ((ctrl_q.app_gen && !ctrl_q.swap && !gen_start_q) |=> !led_second_q)
    else $error("generator indicator lit without start");
  AST_OK_LED: assert property ((first_stat == SRC_OK) |=> led_first_q)
    else $error("indicator dark for good source");
  AST_COOL_TIME: assert property (($past(state_q) == SEQ_COOL && state_q == SEQ_ON_NORMAL)
    |-> $past(sec_q) >= GEN_COOL_S)
    else $error("generator stopped before cool-down time");
  AST_UU_TRANSFER: assert property ((state_q == SEQ_ON_NORMAL && !ctrl_q.app_gen && !norm_ok && alt_ok)
    |=> load_alt_q)
    else $error("load not moved to alternate utility");
  AST_UTIL_NO_OFF: assert property (!ctrl_q.app_gen |-> (first_stat != SRC_OFF && second_stat != SRC_OFF))
    else $error("utility source reported off");

endmodule : tss_sequencer
`default_nettype wire

/* File: tb/tss_gen_model.sv */
// Generator set model: ready a set number of cycles after start
`timescale 1ns/1ps
`default_nettype none
module tss_gen_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic gen_start,
  input wire logic [15:0] ready_cycles,
  output logic gen_ready,
  output logic [3:0] gen_det
);
  logic [15:0] run_q;
  // Zero ready_cycles models a set that never comes up
  always_ff @(posedge aclk) begin
    if (!aresetn || !gen_start) begin
      run_q <= 16'h0;
      gen_ready <= 1'b0;
    end else begin
      run_q <= run_q + 16'h1;
      gen_ready <= (ready_cycles != 16'h0) && (run_q >= ready_cycles);
    end
  end
  // A stopped set shows no voltage on any detection
  assign gen_det = gen_ready ? 4'hf : 4'h0;
endmodule : tss_gen_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the transfer switch sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tss_pkg::*;
  localparam int TK = 10;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] det_u = 8'hff;
  logic aux_power_present = 1'b0;
  logic ug = 1'b0;
  logic [15:0] rdy_cyc = 16'h0;
  logic gen_ready, gen_start, gen_cool_down, load_on_alt, led_first, led_second, gen_alarm, test_alarm;
  logic [3:0] gen_det;
  logic [31:0] d;
  tss_det_t det_in_range;
  int err_count = 0;
  int n_checks = 0;
  int c1, c2;
  // Generator detections replace the second source in generator mode
  assign det_in_range = {ug ? gen_det : det_u[7:4], det_u[3:0]};
  tss_sequencer #(.TICK_CYCLES(TK)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .det_in_range, .aux_power_present, .gen_ready, .gen_start, .gen_cool_down, .load_on_alt,
    .led_first, .led_second, .gen_alarm, .test_alarm
  );
  tss_gen_model u_gen (
    .aclk, .aresetn, .gen_start, .ready_cycles(rdy_cyc), .gen_ready, .gen_det
  );
  initial begin
    forever #4 aclk = ~aclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    // One edge between transfers, so bready never falls and rises in one step
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Counts lit cycles of both indicators over two seconds
  task automatic lc;
    c1 = 0;
    c2 = 0;
    repeat (2 * TK) begin
      @(posedge aclk);
      c1 += led_first;
      c2 += led_second;
    end
  endtask : lc
  task automatic t_reg;
    rd(REG_CTRL);
    chk("ctrl reset", d, 32'h0);
    rd(REG_DET_EN);
    chk("det_en reset", d, 32'hff);
    rd(REG_STATUS);
    chk("status idle", d, 32'h0);
    rd(32'h10);
    chk("unmapped read", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(32'h10, 32'hf);
    chk("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
    $display("t_reg done");
  endtask : t_reg
  task automatic t_uu;
    wr(REG_DET_EN, 32'hfe);
    det_u <= 8'hfe;
    cyc(4);
    chk("disabled detection", load_on_alt, 0);
    det_u <= 8'hfc;
    cyc(4);
    chk("transfer on loss", load_on_alt, 1);
    rd(REG_STATUS);
    chk("first out range", d[3:0], 4'h1);
    lc;
    chk("first blinks", 32'(c1 > 0 && c1 < 2 * TK), 1);
    chk("second steady", c2, 2 * TK);
    det_u <= 8'hff;
    cyc(4);
    chk("no return", load_on_alt, 1);
    wr(REG_CTRL, 32'h2);
    cyc(4);
    chk("auto return", load_on_alt, 0);
    wr(REG_CTRL, 32'h6);
    det_u <= 8'h0f;
    cyc(4);
    chk("swapped loss", load_on_alt, 1);
    det_u <= 8'hff;
    cyc(4);
    chk("swapped return", load_on_alt, 0);
    $display("t_uu done");
  endtask : t_uu
  task automatic t_ug;
    // Generator mode before the generator feeds the second input
    wr(REG_CTRL, 32'hb);
    rdy_cyc <= 16'd50;
    ug <= 1'b1;
    cyc(4);
    rd(REG_STATUS);
    chk("gen off", d[3:2], SRC_OFF);
    chk("gen led off", led_second, 0);
    det_u <= 8'hf0;
    cyc(4);
    chk("start on loss", gen_start, 1);
    rd(REG_STATUS);
    chk("gen starting", d[3:2], SRC_OUT_RANGE);
    chk("wait ready", load_on_alt, 0);
    cyc(60);
    chk("on gen", load_on_alt, 1);
    chk("no early cool", gen_cool_down, 0);
    det_u <= 8'hff;
    cyc(4);
    chk("return", load_on_alt, 0);
    chk("cool after return", gen_cool_down, 1);
    cyc(570);
    chk("still running", gen_start, 1);
    cyc(50);
    chk("stopped", {gen_start, gen_cool_down, gen_alarm}, 0);
    $display("t_ug done");
  endtask : t_ug
  task automatic t_alarm;
    rdy_cyc <= 16'h0;
    det_u <= 8'hf0;
    cyc(3100);
    chk("no aux no alarm", gen_alarm, 0);
    aux_power_present <= 1'b1;
    cyc(2980);
    chk("alarm early", gen_alarm, 0);
    cyc(40);
    chk("alarm set", gen_alarm, 1);
    det_u <= 8'hff;
    cyc(4);
    chk("alarm cleared", gen_alarm, 0);
    chk("cooling", gen_cool_down, 1);
    aresetn <= 1'b0;
    cyc(2);
    chk("reset outputs", {gen_start, gen_cool_down, load_on_alt, led_first, led_second, test_alarm}, 0);
    aresetn <= 1'b1;
    ug <= 1'b0;
    cyc(2);
    $display("t_alarm done");
  endtask : t_alarm
  task automatic t_test;
    wr(REG_CMD, 32'h1);
    cyc(3);
    chk("on-load alarm", test_alarm, 1);
    rd(REG_STATUS);
    chk("test active", d[9], 1);
    wr(REG_CMD, 32'h4);
    wr(REG_CMD, 32'h8);
    cyc(3);
    chk("test alarm clear", test_alarm, 0);
    wr(REG_CMD, 32'h2);
    cyc(3);
    chk("off-load alarm", test_alarm, 1);
    $display("t_test done");
  endtask : t_test
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    cyc(8);
    aresetn <= 1'b1;
    cyc(1);
    t_reg;
    t_uu;
    t_ug;
    t_alarm;
    t_test;
    print_verdict;
  end
  initial begin
    cyc(15000);
    err_count++;
    $display("Error watchdog expected finish seen hang");
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
